//--- block_word_store.v
/*
  block_word_store: word memory holding one block of packed serial bytes.
  assumes a single clock; the write is clocked, the read is combinational.
*/
`timescale 1ns/1ns
module block_word_store #(
  parameter AW = 8,
  parameter DW = 16
) (
  input wire clk,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output wire [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are always written before being read
  always @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

//--- serial_byte_source.sv
/* serial_byte_source: behavioural serial receiver handing one block of
   bytes to the formatter per go pulse. assumes the formatter clock. */
`timescale 1ns/1ns
module serial_byte_source (
  input wire clk,
  input wire go,
  input wire [9:0] n,
  input wire [7:0] seed,
  input wire in_ready,
  output reg in_valid = 1'b0,
  output reg [7:0] in_byte = 8'h00,
  output reg in_last = 1'b0,
  output reg in_first_bit = 1'b0
);
  reg [9:0] k_q = 10'h000;
  // bytes seed, seed+1, ...; each holds until taken
  always @(posedge clk) begin
    in_first_bit <= 1'b0;
    if (go && !in_valid) begin
      in_valid <= 1'b1;
      in_first_bit <= 1'b1;
      in_byte <= seed;
      in_last <= n == 10'h001;
      k_q <= 10'h001;
    end else if (in_valid && in_ready) begin
      in_valid <= !in_last;
      // released line shows the inverse, never a stale byte
      in_byte <= in_last ? ~in_byte : in_byte + 8'h01;
      in_last <= k_q + 10'h001 == n;
      k_q <= k_q + 10'h001;
    end
  end
endmodule

//--- serial_channel_packet_formatter_bench.sv
/* serial_channel_packet_formatter_bench: sends blocks through the formatter
   and checks each emitted word. assumes ce held high throughout. */
`timescale 1ns/1ns
module serial_channel_packet_formatter_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0000_0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [13:0] in_subchannel = 14'h0000;
  reg in_parity_err = 1'b0;
  reg [47:0] rtc = 48'h0000_0000_0000;
  reg out_ready = 1'b0;
  reg go = 1'b0;
  reg [9:0] n = 10'h001;
  reg [7:0] seed = 8'h00;
  reg tag, abs;
  reg [1:0] fmt;
  reg [47:0] stamp;
  reg [63:0] tt;
  reg [28:0] rows [0:4];
  reg [16:0] got [$];
  reg [16:0] want [$];
  integer fails = 0;
  integer cmp_count = 0;
  integer i, k;
  wire [63:0] abs_time = {16'h5a5a, rtc};
  wire [31:0] reg_rdata;
  wire in_valid, in_last, in_first_bit, in_ready, abs_time_en, out_valid, out_last, irq;
  wire [7:0] in_byte;
  wire [1:0] abs_time_fmt;
  wire [15:0] out_word;
  serial_packet_formatter u_serial_packet_formatter (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_byte(in_byte), .in_subchannel(in_subchannel), .in_parity_err(in_parity_err),
    .in_last(in_last), .in_first_bit(in_first_bit), .in_ready(in_ready), .rtc(rtc),
    .abs_time(abs_time), .abs_time_en(abs_time_en), .abs_time_fmt(abs_time_fmt),
    .out_valid(out_valid), .out_word(out_word), .out_last(out_last),
    .out_ready(out_ready), .irq(irq)
  );
  serial_byte_source u_serial_byte_source (
    .clk(clk), .go(go), .n(n), .seed(seed), .in_ready(in_ready), .in_valid(in_valid),
    .in_byte(in_byte), .in_last(in_last), .in_first_bit(in_first_bit)
  );
  task chk(input [31:0] seen, input [31:0] exp_v);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp_v) begin
        fails = fails + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp_v);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always #5 clk = ~clk;
  // free time count; sink stalls one cycle in four
  always @(posedge clk) begin
    rtc <= rtc + 48'h0000_0000_0001;
    out_ready <= rtc[1:0] != 2'h0;
    if (in_first_bit)
      stamp <= rtc;
    if (out_valid && out_ready)
      got.push_back({out_last, out_word});
  end
  initial begin
    #200000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    // tag, absolute, format, bytes, subchannel, parity
    rows[0] = {1'b0, 1'b0, 2'h0, 10'h003, 14'h0000, 1'b0};
    rows[1] = {1'b1, 1'b0, 2'h1, 10'h004, 14'h3fff, 1'b1};
    rows[2] = {1'b1, 1'b1, 2'h2, 10'h001, 14'h0015, 1'b0};
    rows[3] = {1'b0, 1'b1, 2'h3, 10'h006, 14'h2000, 1'b1};
    rows[4] = {1'b1, 1'b0, 2'h0, 10'h1ff, 14'h0007, 1'b0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1 chk(32'({out_valid, in_ready, irq}), 32'h0000_0000);
    chk(reg_rdata, 32'h0000_0000);
    @(posedge clk);
    #1 chk(32'(in_ready), 32'h0000_0001);
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clk);
      {tag, abs, fmt, n, in_subchannel, in_parity_err} <= rows[i];
      seed <= 8'h31 + 8'(i * 7);
      @(posedge clk);
      wr(8'h00, {28'h000_0000, fmt, abs, tag});
      @(posedge clk);
      #1 chk(32'({abs_time_fmt, abs_time_en}), 32'({fmt, abs}));
      wr(8'h04, 32'h0000_0001);
      got = {};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      for (k = 0; in_valid && k < 2000; k = k + 1)
        @(posedge clk);
      tt = {abs ? 16'h5a5a : 16'h0000, stamp};
      want = {};
      want.push_back(17'h0_0000);
      want.push_back({1'b0, tag, 15'h0000});
      for (k = 0; tag && k < 4; k = k + 1)
        want.push_back({1'b0, tt[16*k +: 16]});
      want.push_back({7'h00, n});
      want.push_back({1'b0, in_parity_err, 1'b0, in_subchannel});
      for (k = 0; k < n; k = k + 2)
        want.push_back({1'b0, k + 1 < n ? seed + 8'(k + 1) : 8'h00, seed + 8'(k)});
      want[want.size() - 1][16] = 1'b1;
      for (k = 0; got.size() < want.size() && k < 3000; k = k + 1)
        @(posedge clk);
      repeat (3) @(posedge clk);
      #1 chk(32'(in_ready), 32'h0000_0001);
      chk(32'(in_valid), 32'h0000_0000);
      chk(32'(got.size()), 32'(want.size()));
      foreach (want[j]) chk(32'(got[j]), 32'(want[j]));
    end
    rd(8'h0C, 32'h0000_000B);
    wr(8'h10, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0001);
    wr(8'h0C, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0000);
    rd(8'h0C, 32'h0000_0009);
    rd(8'h40, 32'h0000_0000);
    rd(8'h00, 32'h0000_0001);
    rd(8'h08, 32'h01ff_0000);
    rd(8'h14, 32'h0000_0005);
    print_verdict;
  end
endmodule

//--- serial_fmt_regs.vh
/*
  register offsets, field positions and sizes of the serial packet formatter.
  assumes byte addresses on an 8-bit register port with 32-bit data.
*/
`ifndef SERIAL_FMT_REGS_VH
`define SERIAL_FMT_REGS_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_INT_STAT 8'h0C
`define REG_INT_MASK 8'h10
`define REG_BLK_CNT 8'h14

// control fields
`define CTRL_TAG_BIT 0
`define CTRL_ABS_BIT 1
`define CTRL_FMT_LO 2
`define CTRL_FMT_HI 3
`define CTRL_RESET 4'h0
`define CMD_CLOSE_BIT 0

// interrupt status bits
`define EV_BLOCK 0
`define EV_PARITY 1
`define EV_FULL 2
`define EV_CLOSED 3
`define EV_W 4

// packet word layout
`define CW_TAG_BIT 31
`define DESC_PAR_BIT 31
`define DESC_SUB_HI 29
`define DESC_SUB_LO 16
`define DESC_LEN_HI 15

// block store: 256 words of 16 bits, 512 bytes
`define BUF_AW 8
`define MAX_BYTES 16'h0200

`endif

//--- serial_packet_formatter.v
/*
  serial_packet_formatter: collects one block of serial bytes at a time and
  writes it into a packet body as 16-bit words with its own block header.
  assumes byte sources, the relative time counter and the absolute time
  source all run on clk; the register port is a plain strobe port.
*/
//
// Functional notes
// - bytes from many serial channels, one body
// - channel word bit 31 flags time tags
// - channel word bits 30-0 read zero
// - every block gets its own header
// - header: low time, high time, descriptor
// - default tag is 48-bit relative time
// - absolute time when enabled, format passed on
// - descriptor word always sent
// - descriptor bit 31 parity, bit 30 zero
// - descriptor bits 29-16 hold subchannel
// - descriptor bits 15-0 hold byte count
// - two bytes per word, earlier byte low
`timescale 1ns/1ns
`include "serial_fmt_regs.vh"
module serial_packet_formatter (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire in_valid,
  input wire [7:0] in_byte,
  input wire [13:0] in_subchannel,
  input wire in_parity_err,
  input wire in_last,
  input wire in_first_bit,
  output reg in_ready,
  input wire [47:0] rtc,
  input wire [63:0] abs_time,
  output reg abs_time_en,
  output reg [1:0] abs_time_fmt,
  output reg out_valid,
  output reg [15:0] out_word,
  output reg out_last,
  input wire out_ready,
  output reg irq
);
  // sequencer states, one-hot
  localparam [9:0] S_COLLECT = 10'h001;
  localparam [9:0] S_CW0 = 10'h002;
  localparam [9:0] S_CW1 = 10'h004;
  localparam [9:0] S_TL0 = 10'h008;
  localparam [9:0] S_TL1 = 10'h010;
  localparam [9:0] S_TH0 = 10'h020;
  localparam [9:0] S_TH1 = 10'h040;
  localparam [9:0] S_DD0 = 10'h080;
  localparam [9:0] S_DD1 = 10'h100;
  localparam [9:0] S_DATA = 10'h200;

  reg [9:0] state_q;
  reg [3:0] ctrl_q;
  reg [`EV_W-1:0] int_stat_q;
  reg [`EV_W-1:0] int_mask_q;
  reg [31:0] blk_cnt_q;
  reg pkt_open_q;
  reg pkt_tag_q;
  reg close_pend_q;
  reg [15:0] byte_cnt_q;
  reg [7:0] lo_byte_q;
  reg parity_q;
  reg [13:0] sub_q;
  reg [63:0] tag_q;
  reg tag_held_q;
  reg [`BUF_AW-1:0] widx_q;
  reg [15:0] last_len_q;

  wire [15:0] mem_rd;
  wire take;
  wire advance;
  wire ends_block;
  wire is_full;
  wire [15:0] cnt_inc;
  wire [63:0] time_now;
  wire [31:0] desc_word;
  wire [`BUF_AW-1:0] last_widx;
  wire cmd_close;
  wire stat_clr_wr;
  reg [`EV_W-1:0] ev;
  reg mem_we;
  reg [15:0] mem_wd;
  reg [31:0] rd_mux;

  // byte accepted from a serial source; all channels share one body
  assign take = in_valid && in_ready;
  assign cnt_inc = byte_cnt_q + 16'h0001;
  // the 512th byte closes the block even without a last flag
  assign is_full = (cnt_inc == `MAX_BYTES);
  assign ends_block = take && (in_last || is_full);
  // output register can take a new word
  assign advance = !out_valid || out_ready;
  assign cmd_close = reg_wr && (reg_addr == `REG_CMD) && reg_wdata[`CMD_CLOSE_BIT];
  assign stat_clr_wr = reg_wr && (reg_addr == `REG_INT_STAT);

  // relative time sits in 48 bits, upper 16 zero
  assign time_now = ctrl_q[`CTRL_ABS_BIT] ? abs_time : {16'h0000, rtc};

  // parity flag, reserved bit, subchannel, byte count
  assign desc_word = {parity_q, 1'b0, sub_q, byte_cnt_q};

  // word index of the last data word, (count + 1) / 2 - 1
  assign last_widx = byte_cnt_q[`BUF_AW:1] + {{(`BUF_AW-1){1'b0}}, byte_cnt_q[0]}
    - {{(`BUF_AW-1){1'b0}}, 1'b1};

  // holds one block while it is sent; the source waits on in_ready
  block_word_store #(
    .AW(`BUF_AW),
    .DW(16)
  ) u_store (
    .clk(clk),
    .ce(ce),
    .wr_en(mem_we),
    .wr_addr(byte_cnt_q[`BUF_AW:1]),
    .wr_data(mem_wd),
    .rd_addr(widx_q),
    .rd_data(mem_rd)
  );

  // packing: a word is written when its high byte arrives, or alone at
  // the end of an odd block with the filler forced to zero
  always @* begin
    mem_we = 1'b0;
    mem_wd = 16'h0000;
    if (take && state_q == S_COLLECT) begin
      if (byte_cnt_q[0]) begin
        mem_we = 1'b1;
        mem_wd = {in_byte, lo_byte_q};
      end else if (ends_block) begin
        mem_we = 1'b1;
        mem_wd = {8'h00, in_byte};
      end
    end
  end

  // hardware events for the sticky status register
  always @* begin
    ev = {`EV_W{1'b0}};
    ev[`EV_FULL] = ends_block && !in_last;
    if (state_q == S_DATA && advance && widx_q == last_widx) begin
      ev[`EV_BLOCK] = 1'b1;
      ev[`EV_PARITY] = parity_q;
      ev[`EV_CLOSED] = close_pend_q;
    end
  end

  // register read multiplexer; unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `REG_CTRL: rd_mux = {28'h000_0000, ctrl_q};
      `REG_STATUS: rd_mux = {last_len_q, 13'h0000, close_pend_q,
        (state_q != S_COLLECT), pkt_open_q};
      `REG_INT_STAT: rd_mux = {28'h000_0000, int_stat_q};
      `REG_INT_MASK: rd_mux = {28'h000_0000, int_mask_q};
      `REG_BLK_CNT: rd_mux = blk_cnt_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // register port and interrupt; read data stand only in the next cycle
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
      int_stat_q <= {`EV_W{1'b0}};
      int_mask_q <= {`EV_W{1'b0}};
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
      abs_time_en <= 1'b0;
      abs_time_fmt <= 2'b00;
    end else if (ce) begin
      if (reg_wr && reg_addr == `REG_CTRL) begin
        ctrl_q <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `REG_INT_MASK) begin
        int_mask_q <= reg_wdata[`EV_W-1:0];
      end
      // a new event beats a clear written in the same cycle
      int_stat_q <= (int_stat_q & ~(stat_clr_wr ? reg_wdata[`EV_W-1:0] :
        {`EV_W{1'b0}})) | ev;
      irq <= |(int_stat_q & int_mask_q);
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      // time source selection and format go out to the time source
      abs_time_en <= ctrl_q[`CTRL_ABS_BIT];
      abs_time_fmt <= ctrl_q[`CTRL_FMT_HI:`CTRL_FMT_LO];
    end
  end

  // byte collection: count, parity, subchannel, time of first data bit
  always @(posedge clk) begin
    if (rst) begin
      byte_cnt_q <= 16'h0000;
      lo_byte_q <= 8'h00;
      parity_q <= 1'b0;
      sub_q <= 14'h0000;
      tag_q <= 64'h0000_0000_0000_0000;
      tag_held_q <= 1'b0;
      in_ready <= 1'b0;
      last_len_q <= 16'h0000;
    end else if (ce) begin
      if (state_q == S_COLLECT) begin
        // latch at the start bit of the first byte, or at the byte itself
        if (!tag_held_q && byte_cnt_q == 16'h0000 && (in_first_bit || take)) begin
          tag_q <= time_now;
          tag_held_q <= 1'b1;
        end
        if (take) begin
          lo_byte_q <= in_byte;
          byte_cnt_q <= cnt_inc;
          parity_q <= parity_q | in_parity_err;
          if (byte_cnt_q == 16'h0000) begin
            sub_q <= in_subchannel;
          end
        end
        // stop taking bytes once the block is complete
        in_ready <= !ends_block;
      end else begin
        in_ready <= 1'b0;
        if (state_q == S_DATA && advance && widx_q == last_widx) begin
          last_len_q <= byte_cnt_q;
          byte_cnt_q <= 16'h0000;
          parity_q <= 1'b0;
          tag_held_q <= 1'b0;
          in_ready <= 1'b1;
        end
      end
    end
  end

  // emission sequencer: channel word, header words, data words
  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_COLLECT;
      out_valid <= 1'b0;
      out_word <= 16'h0000;
      out_last <= 1'b0;
      widx_q <= {`BUF_AW{1'b0}};
      pkt_open_q <= 1'b0;
      pkt_tag_q <= 1'b0;
      close_pend_q <= 1'b0;
      blk_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (cmd_close) begin
        close_pend_q <= 1'b1;
      end
      // a block end is caught even while the sink still holds the last
      // word of the previous block; missing it would merge two blocks
      if (state_q == S_COLLECT && ends_block) begin
        widx_q <= {`BUF_AW{1'b0}};
        // a new packet opens with its channel word
        if (pkt_open_q) begin
          state_q <= pkt_tag_q ? S_TL0 : S_DD0;
        end else begin
          state_q <= S_CW0;
          // tag choice is frozen for the packet's lifetime
          pkt_tag_q <= ctrl_q[`CTRL_TAG_BIT];
          pkt_open_q <= 1'b1;
        end
      end
      if (advance) begin
        out_valid <= 1'b0;
        out_last <= 1'b0;
        case (state_q)
          S_COLLECT: begin
            widx_q <= {`BUF_AW{1'b0}};
          end
          S_CW0: begin
            out_valid <= 1'b1;
            out_word <= 16'h0000;
            state_q <= S_CW1;
          end
          S_CW1: begin
            out_valid <= 1'b1;
            out_word <= {pkt_tag_q, 15'h0000};
            state_q <= pkt_tag_q ? S_TL0 : S_DD0;
          end
          // header words contiguous: low time, high time, descriptor
          S_TL0: begin
            out_valid <= 1'b1;
            out_word <= tag_q[15:0];
            state_q <= S_TL1;
          end
          S_TL1: begin
            out_valid <= 1'b1;
            out_word <= tag_q[31:16];
            state_q <= S_TH0;
          end
          S_TH0: begin
            out_valid <= 1'b1;
            out_word <= tag_q[47:32];
            state_q <= S_TH1;
          end
          S_TH1: begin
            out_valid <= 1'b1;
            out_word <= tag_q[63:48];
            state_q <= S_DD0;
          end
          // descriptor sent for every block regardless of tags
          S_DD0: begin
            out_valid <= 1'b1;
            out_word <= desc_word[15:0];
            state_q <= S_DD1;
          end
          S_DD1: begin
            out_valid <= 1'b1;
            out_word <= desc_word[31:16];
            state_q <= S_DATA;
          end
          S_DATA: begin
            out_valid <= 1'b1;
            out_word <= mem_rd;
            if (widx_q == last_widx) begin
              state_q <= S_COLLECT;
              blk_cnt_q <= blk_cnt_q + 32'h0000_0001;
              // a close request ends the packet after this block
              out_last <= close_pend_q;
              if (close_pend_q) begin
                pkt_open_q <= 1'b0;
                close_pend_q <= cmd_close;
              end
            end else begin
              widx_q <= widx_q + {{(`BUF_AW-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            state_q <= S_COLLECT;
          end
        endcase
      end
    end
  end
endmodule

//--- serial_packet_formatter_properties.sv
/* formatter_checks: port timing checks for the serial packet formatter.
   assumes one clock, synchronous high reset, ce held high. */
`timescale 1ns/1ns
module formatter_checks (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire in_valid,
  input wire in_last,
  input wire in_ready,
  input wire abs_time_en,
  input wire [1:0] abs_time_fmt,
  input wire out_valid,
  input wire [15:0] out_word,
  input wire out_last,
  input wire out_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // control write seen at the port
  wire ctl_wr = reg_wr && reg_addr == 8'h00;
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_word) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word moved");
  property p_drop;
    in_valid && in_ready && in_last |=> !in_ready;
  endproperty
  a_drop: assert property (p_drop) else $error("ready after block end");
  property p_emit;
    $fell(in_ready) |-> ##[0:3] out_valid;
  endproperty
  a_emit: assert property (p_emit) else $error("no header after block");
  // shortest header plus data is three words
  property p_gap;
    $fell(in_ready) |-> !in_ready [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("header cut short");
  property p_back;
    $fell(out_valid) |-> in_ready || $past(in_ready);
  endproperty
  a_back: assert property (p_back) else $error("input not reopened");
  property p_last;
    out_last |-> out_valid;
  endproperty
  a_last: assert property (p_last) else $error("last flag without word");
  // control register lands at the write edge, the copy one edge later
  property p_abs;
    $past(ctl_wr, 2) |-> abs_time_en == $past(reg_wdata[1], 2);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute enable not passed");
  property p_fmt;
    $past(ctl_wr, 2) |-> abs_time_fmt == $past(reg_wdata[3:2], 2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("time format not passed");
  c_stall: cover property (out_valid && !out_ready);
  c_last: cover property (out_valid && out_ready && out_last);
  c_abs: cover property (abs_time_en);
endmodule
bind serial_packet_formatter formatter_checks u_formatter_checks (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .in_valid(in_valid), .in_last(in_last), .in_ready(in_ready), .abs_time_en(abs_time_en),
  .abs_time_fmt(abs_time_fmt), .out_valid(out_valid), .out_word(out_word),
  .out_last(out_last), .out_ready(out_ready)
);
